// ---- src/rx_flags_pkg.sv ----
// Purpose: shared constants for the receiver flag block
// Assumes: character lengths 5..8, rate factor 1, 16 or 64
// Notes:   all codes and the pin and idle-line reset values live here
package rx_flags_pkg;

	// ----------------------------------------
	// character format
	// ----------------------------------------
	localparam int unsigned CHAR_MIN_BITS = 5;
	localparam int unsigned CHAR_MAX_BITS = 8;
	localparam int unsigned START_BITS    = 1;
	localparam int unsigned BREAK_FRAMES  = 2;
	localparam int unsigned TICK_W        = 12;

	// ----------------------------------------
	// mode codes
	// ----------------------------------------
	localparam logic [1:0] FACTOR_X1  = 2'h1;
	localparam logic [1:0] FACTOR_X16 = 2'h2;
	localparam logic [1:0] FACTOR_X64 = 2'h3;
	localparam int unsigned FACTOR_16 = 16;
	localparam int unsigned FACTOR_64 = 64;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic PIN_RESET_LEVEL = 1'b0;
	localparam logic PIN_RESET_OE    = 1'b1;
	localparam logic LINE_IDLE       = 1'b1;

	// ----------------------------------------
	// sync hunt states
	// ----------------------------------------
	typedef enum logic [1:0] {
		HUNT_FIRST  = 2'b00,
		HUNT_SECOND = 2'b01,
		LOCKED      = 2'b10
	} hunt_state_t;

endpackage

// ---- src/rx_line_if.sv ----
// Purpose: carries sampled line events from sampler to flag core
// Assumes: both ends on clock_in
// Notes:   all signals are single-cycle pulses or levels
`timescale 1ns/1ps
`default_nettype none
interface rx_line_if;
	logic bit_tick;    // rising edge of bit clock seen
	logic bit_val;     // data level sampled with bit_tick
	logic line_level;  // synchronised data level
	logic ext_rise;    // rising edge on sync pin input

	modport sampler (output bit_tick, output bit_val, output line_level, output ext_rise);
	modport core    (input bit_tick, input bit_val, input line_level, input ext_rise);
endinterface
`default_nettype wire

// ---- src/rx_line_sampler.sv ----
// Purpose: synchronise receive pins and find bit clock edges
// Assumes: clock_in far faster than the bit clock
// Notes:   first synchroniser stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module rx_line_sampler (
	input  wire logic  clock_in,
	input  wire logic  rst_n_in,
	input  wire logic  rx_bit_clock_in,
	input  wire logic  rx_data_in,
	input  wire logic  sync_pin_in,
	rx_line_if.sampler line
);

	logic [1:0] clk_sync_q;
	logic [1:0] dat_sync_q;
	logic [1:0] pin_sync_q;
	logic       clk_prev_q;
	logic       pin_prev_q;

	// ----------------------------------------
	// two-stage synchronisers
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_sync_q <= 2'h0;
			dat_sync_q <= {2{rx_flags_pkg::LINE_IDLE}};
			pin_sync_q <= 2'h0;
		end else begin
			clk_sync_q <= {clk_sync_q[0], rx_bit_clock_in};
			dat_sync_q <= {dat_sync_q[0], rx_data_in};
			pin_sync_q <= {pin_sync_q[0], sync_pin_in};
		end
	end

	// ----------------------------------------
	// edge finders on the settled stage
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_prev_q      <= 1'b0;
			pin_prev_q      <= 1'b0;
			line.bit_tick   <= 1'b0;
			line.bit_val    <= rx_flags_pkg::LINE_IDLE;
			line.line_level <= rx_flags_pkg::LINE_IDLE;
			line.ext_rise   <= 1'b0;
		end else begin
			clk_prev_q      <= clk_sync_q[1];
			pin_prev_q      <= pin_sync_q[1];
			line.bit_tick   <= clk_sync_q[1] & ~clk_prev_q;
			line.bit_val    <= dat_sync_q[1];
			line.line_level <= dat_sync_q[1];
			line.ext_rise   <= pin_sync_q[1] & ~pin_prev_q;
		end
	end

endmodule // rx_line_sampler
`default_nettype wire

// ---- src/rx_sync_break_flags.sv ----
// Purpose: receive flags, sync detect and break detect
// Assumes: character assembler and status port sit outside
// Notes:   pins pass three flip-flops in the sampler first
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - flag a complete received character waiting in the buffer
// - character-available also shown as a status bit
// - receiver disabled forces and holds character-available low
// - sync mode: pin is output for internal sync, input for external
// - reset leaves the dual pin an output driven low
// - internal sync: drive pin high once sync pattern is matched
// - double sync: raise at mid last bit of second character
// - every status read clears sync detect unless a match sets it in the same cycle
// - external rising sync input starts assembly at next bit clock rise
// - async mode: dual pin shows break detect
// - break when data stays low through two whole frames
// - break also shown as a status bit
// - break clears only on reset, line high or sync mode, not on status read
// - serial data sampled on bit clock rising edges
module rx_sync_break_flags (
	input  wire logic       clock_in,
	input  wire logic       reset_n_in,
	input  wire logic       rx_bit_clock_in,
	input  wire logic       rx_data_in,
	input  wire logic       sync_or_break_pin_in,
	input  wire logic       rx_enable_in,
	input  wire logic       sync_mode_in,
	input  wire logic       ext_sync_in,
	input  wire logic       double_sync_in,
	input  wire logic [1:0] char_len_in,
	input  wire logic       parity_en_in,
	input  wire logic       two_stop_in,
	input  wire logic [1:0] rate_factor_in,
	input  wire logic [7:0] sync_char1_in,
	input  wire logic [7:0] sync_char2_in,
	input  wire logic       char_loaded_in,
	input  wire logic       data_read_in,
	input  wire logic       status_read_in,
	output logic            rx_char_available_out,
	output logic            sync_or_break_pin_out,
	output logic            sync_or_break_pin_oe_out,
	output logic            status_rx_avail_out,
	output logic            status_sync_out,
	output logic            status_break_out,
	output logic            assemble_start_out
);

	localparam int unsigned TW = rx_flags_pkg::TICK_W;

	logic [1:0]                    rst_sync_q;
	logic                          rst_n;
	logic                          avail_q;
	logic                          sync_found_q;
	logic                          break_found_q;
	logic                          ext_armed_q;
	logic [7:0]                    shift_q;
	logic [3:0]                    bit_cnt_q;
	logic [TW-1:0]                 low_cnt_q;
	rx_flags_pkg::hunt_state_t     hunt_q;
	logic                          internal_sync;
	logic                          external_sync;
	logic [7:0]                    shift_d;

	rx_line_if line ();

	rx_line_sampler sampler (
		.clock_in        (clock_in),
		.rst_n_in        (rst_n),
		.rx_bit_clock_in (rx_bit_clock_in),
		.rx_data_in      (rx_data_in),
		.sync_pin_in     (sync_or_break_pin_in),
		.line            (line)
	);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// true when the newest char_len bits equal the pattern
	function automatic logic pattern_hit(input logic [7:0] sr, input logic [7:0] pat,
		input logic [1:0] len);
		logic [7:0] got;
		logic [7:0] mask;
		got  = sr >> (3'(3) - 3'(len));
		mask = 8'hff >> (3'(3) - 3'(len));
		return (got & mask) == (pat & mask);
	endfunction

	// bit clock ticks in two complete frames
	function automatic logic [TW-1:0] break_ticks(input logic [1:0] len, input logic par,
		input logic stop2, input logic [1:0] fac);
		logic [TW-1:0] bits;
		logic [TW-1:0] mult;
		bits = TW'(rx_flags_pkg::START_BITS) + TW'(rx_flags_pkg::CHAR_MIN_BITS)
			+ TW'(len) + TW'(par) + TW'(stop2) + TW'(1);
		case (fac)
			rx_flags_pkg::FACTOR_X16: mult = TW'(rx_flags_pkg::FACTOR_16);
			rx_flags_pkg::FACTOR_X64: mult = TW'(rx_flags_pkg::FACTOR_64);
			default:                  mult = TW'(1);
		endcase
		return TW'(bits * mult * TW'(rx_flags_pkg::BREAK_FRAMES));
	endfunction

	assign internal_sync = sync_mode_in & ~ext_sync_in;
	assign external_sync = sync_mode_in & ext_sync_in;
	assign shift_d       = {line.bit_val, shift_q[7:1]};

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// character available flag
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			avail_q <= 1'b0;
		end else if (!rx_enable_in) begin
			avail_q <= 1'b0;
		end else if (char_loaded_in) begin
			avail_q <= 1'b1;
		end else if (data_read_in) begin
			avail_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// serial shift register
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= 8'h00;
		end else if (line.bit_tick) begin
			shift_q <= shift_d;
		end
	end

	// ----------------------------------------
	// sync character hunt
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			hunt_q    <= rx_flags_pkg::HUNT_FIRST;
			bit_cnt_q <= 4'h0;
		end else if (!rx_enable_in || !internal_sync) begin
			hunt_q    <= rx_flags_pkg::HUNT_FIRST;
			bit_cnt_q <= 4'h0;
		end else if (line.bit_tick) begin
			case (hunt_q)
				rx_flags_pkg::HUNT_FIRST: begin
					if (pattern_hit(shift_d, sync_char1_in, char_len_in)) begin
						hunt_q    <= double_sync_in ? rx_flags_pkg::HUNT_SECOND
							: rx_flags_pkg::LOCKED;
						bit_cnt_q <= 4'h0;
					end
				end
				rx_flags_pkg::HUNT_SECOND: begin
					bit_cnt_q <= bit_cnt_q + 4'h1;
					if (bit_cnt_q == 4'(rx_flags_pkg::CHAR_MIN_BITS - 1) + 4'(char_len_in)) begin
						hunt_q <= pattern_hit(shift_d, sync_char2_in, char_len_in)
							? rx_flags_pkg::LOCKED : rx_flags_pkg::HUNT_FIRST;
					end
				end
				rx_flags_pkg::LOCKED: begin
					hunt_q <= rx_flags_pkg::LOCKED;
				end
				default: begin
					hunt_q <= rx_flags_pkg::HUNT_FIRST;
				end
			endcase
		end
	end

	// ----------------------------------------
	// sync detect flag
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			sync_found_q <= rx_flags_pkg::PIN_RESET_LEVEL;
		end else if (line.bit_tick && internal_sync && rx_enable_in
			&& ((hunt_q == rx_flags_pkg::HUNT_FIRST && !double_sync_in
				&& pattern_hit(shift_d, sync_char1_in, char_len_in))
			|| (hunt_q == rx_flags_pkg::HUNT_SECOND
				&& bit_cnt_q == 4'(rx_flags_pkg::CHAR_MIN_BITS - 1) + 4'(char_len_in)
				&& pattern_hit(shift_d, sync_char2_in, char_len_in)))) begin
			sync_found_q <= 1'b1;
		end else if (status_read_in) begin
			sync_found_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// external sync start
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			ext_armed_q        <= 1'b0;
			assemble_start_out <= 1'b0;
		end else begin
			assemble_start_out <= 1'b0;
			if (!external_sync || !rx_enable_in) begin
				ext_armed_q <= 1'b0;
			end else if (line.ext_rise) begin
				ext_armed_q <= 1'b1;
			end else if (ext_armed_q && line.bit_tick) begin
				ext_armed_q        <= 1'b0;
				assemble_start_out <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// break detect
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_q     <= '0;
			break_found_q <= 1'b0;
		end else if (line.line_level || sync_mode_in) begin
			low_cnt_q     <= '0;
			break_found_q <= 1'b0;
		end else if (line.bit_tick) begin
			if (low_cnt_q + TW'(1) >= break_ticks(char_len_in, parity_en_in, two_stop_in,
				rate_factor_in)) begin
				break_found_q <= 1'b1;
			end else begin
				low_cnt_q <= low_cnt_q + TW'(1);
			end
		end
	end

	// ----------------------------------------
	// pin and status outputs
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			sync_or_break_pin_out    <= rx_flags_pkg::PIN_RESET_LEVEL;
			sync_or_break_pin_oe_out <= rx_flags_pkg::PIN_RESET_OE;
			rx_char_available_out    <= 1'b0;
			status_rx_avail_out      <= 1'b0;
			status_sync_out          <= 1'b0;
			status_break_out         <= 1'b0;
		end else begin
			sync_or_break_pin_oe_out <= ~external_sync;
			sync_or_break_pin_out    <= sync_mode_in ? sync_found_q : break_found_q;
			rx_char_available_out    <= avail_q & rx_enable_in;
			status_rx_avail_out      <= avail_q & rx_enable_in;
			status_sync_out          <= sync_found_q;
			status_break_out         <= break_found_q;
		end
	end

endmodule // rx_sync_break_flags
`default_nettype wire

// ---- dv/rx_flags_sva.sv ----
// Purpose: port checks for the receive flag block
// Assumes: bound to the top module, one clock domain
// Notes:   latencies as handed over by the designer
`timescale 1ns/1ps
`default_nettype none
module rx_flags_sva (
	input wire logic clock_in, reset_n_in, rx_data_in, rx_enable_in, sync_mode_in, ext_sync_in,
	input wire logic char_loaded_in, data_read_in, status_read_in, rx_char_available_out,
	input wire logic sync_or_break_pin_out, sync_or_break_pin_oe_out, status_rx_avail_out,
	input wire logic status_sync_out, status_break_out, assemble_start_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	avail_set_a: assert property (
		char_loaded_in && rx_enable_in ##1 rx_enable_in[*2] |-> rx_char_available_out)
		else $error("char available not raised");
	avail_clr_a: assert property (data_read_in && !char_loaded_in |-> ##2 !rx_char_available_out)
		else $error("char available not cleared");
	avail_off_a: assert property (!rx_enable_in[*3] |-> !rx_char_available_out)
		else $error("char available while disabled");
	avail_stat_a: assert property (status_rx_avail_out == rx_char_available_out)
		else $error("status bit differs from pin");
	// reset must have been seen at two edges before the outputs are judged
	pin_reset_a: assert property (disable iff (1'b0)
		(!reset_n_in)[*2] |-> sync_or_break_pin_oe_out && !sync_or_break_pin_out)
		else $error("dual pin wrong in reset");
	pin_dir_a: assert property (
		$stable({sync_mode_in, ext_sync_in})[*5] |-> sync_or_break_pin_oe_out == !(sync_mode_in && ext_sync_in))
		else $error("dual pin direction wrong");
	sync_clr_a: assert property (status_read_in && sync_mode_in && !ext_sync_in |-> ##2 !status_sync_out)
		else $error("sync not cleared by status read");
	brk_hold_a: assert property (
		(!rx_data_in && !sync_mode_in)[*6] ##0 status_break_out |=> status_break_out)
		else $error("break dropped while line low");
	brk_pin_a: assert property (!sync_mode_in[*3] |-> sync_or_break_pin_out == status_break_out)
		else $error("pin does not show break");
	start_once_a: assert property (
		assemble_start_out |-> (sync_mode_in && ext_sync_in) ##1 !assemble_start_out)
		else $error("assembly start pulse wrong");
	// main scenarios reached
	cover property (rx_char_available_out);
	cover property (status_break_out);
	cover property (status_sync_out);
	cover property (assemble_start_out);
endmodule // rx_flags_sva
bind rx_sync_break_flags rx_flags_sva chk (.*);
`default_nettype wire

// ---- dv/rx_line_model.sv ----
// Purpose: serial line partner feeding bit clock and data
// Assumes: called at falling edges of the system clock
// Notes:   clock stands low between frames, line idles high
`timescale 1ns/1ps
`default_nettype none
module rx_line_model (
	output logic bit_clock_out,
	output logic data_out
);
	// idle line state
	initial begin
		bit_clock_out = 1'b0;
		data_out      = 1'b1;
	end
	// bits lsb first, data moves only while clock is low
	task automatic send(input logic [31:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			data_out = bits[i];
			#400 bit_clock_out = 1'b1;
			#400 bit_clock_out = 1'b0;
		end
	endtask
endmodule // rx_line_model
`default_nettype wire

// ---- dv/rx_sync_break_flags_tb_top.sv ----
// Purpose: self-checking bench for the receive flag block
// Assumes: inputs move on falling clock edges
// Notes:   random traffic from a fixed seed plus corner cases
`timescale 1ns/1ps
`default_nettype none
module rx_sync_break_flags_tb_top;
	logic clock_in = 1'b0, reset_n_in = 1'b0, ext_pin_drive = 1'b0, rx_enable_in = 1'b0;
	logic sync_mode_in = 1'b0, ext_sync_in = 1'b0, double_sync_in = 1'b0, parity_en_in = 1'b0;
	logic two_stop_in = 1'b0, char_loaded_in = 1'b0, data_read_in = 1'b0, status_read_in = 1'b0;
	logic [1:0] char_len_in = 2'h3, rate_factor_in = 2'h1;
	logic [7:0] sync_char1_in = 8'h00, sync_char2_in = 8'h00;
	wire logic rx_bit_clock_in, rx_data_in, sync_or_break_pin_in;
	logic rx_char_available_out, sync_or_break_pin_out, sync_or_break_pin_oe_out;
	logic status_rx_avail_out, status_sync_out, status_break_out, assemble_start_out;
	logic d1 = 1'b0, d2 = 1'b0, en_prev = 1'b0;
	int fail_count = 0, total_checks = 0, starts = 0, n, st = 0;
	integer seed = 32'h7057;

	rx_sync_break_flags uut (.*);
	rx_line_model lnk (.bit_clock_out(rx_bit_clock_in), .data_out(rx_data_in));
	// dual pin: device level while it drives, far-end driver otherwise
	assign sync_or_break_pin_in = sync_or_break_pin_oe_out ? sync_or_break_pin_out : ext_pin_drive;

	// ----------------------------------------
	// clock, start counter, helpers
	// ----------------------------------------
	always #50 clock_in = ~clock_in;
	always @(negedge clock_in) if (assemble_start_out === 1'b1) starts++;
	task automatic wt(input int k);
		repeat (k) @(negedge clock_in);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		wt(1);
		s = 1'b0;
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// low ticks needed for two whole frames
	function automatic int brk_ticks(input logic [1:0] l, input logic p, input logic s, input logic [1:0] f);
		brk_ticks = rx_flags_pkg::BREAK_FRAMES * (rx_flags_pkg::START_BITS + rx_flags_pkg::CHAR_MIN_BITS + l + p + 1 + s)
			* (f == rx_flags_pkg::FACTOR_X16 ? 16 : f == rx_flags_pkg::FACTOR_X64 ? 64 : 1);
	endfunction

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		#4ms;
		fail_count++;
		final_report();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		wt(16);
		chk("pin oe in reset", 1'b1, sync_or_break_pin_oe_out);
		chk("pin in reset", 1'b0, sync_or_break_pin_out);
		reset_n_in = 1'b1;
		rx_enable_in = 1'b1;
		wt(4);
		// random loads, reads and enable drops against a flag model
		repeat (300) begin
			if (st >= 3) chk("char available", d2, rx_char_available_out);
			char_loaded_in = ($random(seed) & 3) == 0;
			data_read_in = ($random(seed) & 3) == 0;
			rx_enable_in = ($random(seed) & 15) != 0;
			@(posedge clock_in);
			d2 = d1;
			d1 = rx_enable_in && (char_loaded_in || (d1 && !data_read_in));
			st = (rx_enable_in == en_prev) ? st + 1 : 0;
			en_prev = rx_enable_in;
			@(negedge clock_in);
		end
		char_loaded_in = 1'b0;
		data_read_in = 1'b0;
		rx_enable_in = 1'b1;
		wt(3);
		pulse(char_loaded_in);
		wt(3);
		chk("char available", 1'b1, status_rx_avail_out);
		rx_enable_in = 1'b0;
		wt(4);
		chk("masked flag", 1'b0, rx_char_available_out);
		rx_enable_in = 1'b1;
		wt(4);
		chk("flag after enable", 1'b0, rx_char_available_out);
		// break in async mode, random formats, one x16 and one x64 case
		for (int k = 0; k < 4; k++) begin
			{char_len_in, parity_en_in, two_stop_in} = 4'($random(seed));
			rate_factor_in = (k == 3) ? rx_flags_pkg::FACTOR_X64
				: (k == 2) ? rx_flags_pkg::FACTOR_X16 : rx_flags_pkg::FACTOR_X1;
			n = brk_ticks(char_len_in, parity_en_in, two_stop_in, rate_factor_in);
			repeat (n - 1) lnk.send(32'h0, 1);
			wt(8);
			chk("break early", 1'b0, status_break_out);
			lnk.send(32'h0, 1);
			wt(8);
			chk("break status", 1'b1, status_break_out);
			chk("break pin", 1'b1, sync_or_break_pin_out);
			pulse(status_read_in);
			wt(4);
			chk("break after read", 1'b1, status_break_out);
			lnk.send(32'h1, 1);
			wt(8);
			chk("break cleared", 1'b0, status_break_out);
		end
		// internal double sync hunt, shifter primed with ones first
		lnk.send(32'hff, 8);
		sync_mode_in = 1'b1;
		double_sync_in = 1'b1;
		char_len_in = 2'h3;
		sync_char1_in = 8'($random(seed)) & 8'hfe;
		sync_char2_in = 8'($random(seed));
		wt(4);
		lnk.send({24'h0, sync_char1_in}, 8);
		wt(8);
		chk("sync after first", 1'b0, status_sync_out);
		lnk.send({24'h0, sync_char2_in}, 8);
		wt(8);
		chk("sync status", 1'b1, status_sync_out);
		chk("sync pin", 1'b1, sync_or_break_pin_out);
		chk("sync pin oe", 1'b1, sync_or_break_pin_oe_out);
		pulse(status_read_in);
		wt(4);
		chk("sync after read", 1'b0, status_sync_out);
		chk("sync pin after read", 1'b0, sync_or_break_pin_out);
		// single sync: hunt reopened by a receiver disable
		double_sync_in = 1'b0;
		rx_enable_in = 1'b0;
		lnk.send(32'hff, 8);
		rx_enable_in = 1'b1;
		wt(4);
		lnk.send({24'h0, sync_char1_in}, 8);
		wt(8);
		chk("single sync", 1'b1, status_sync_out);
		// external sync: pin becomes input, one start per rise
		ext_sync_in = 1'b1;
		wt(6);
		chk("pin oe external", 1'b0, sync_or_break_pin_oe_out);
		starts = 0;
		ext_pin_drive = 1'b1;
		wt(8);
		chk("no start before tick", 1'b1, starts == 0);
		lnk.send(32'h0, 2);
		wt(8);
		chk("single start", 1'b1, starts == 1);
		final_report();
	end
endmodule // rx_sync_break_flags_tb_top
`default_nettype wire
